// ---- verilog/spmc_top.sv ----
// serial port control register with mode decode and done flags
// assumes an APB master on clk and a shift datapath on the same clock
`timescale 1ns/1ps
`include "spmc_defs.svh"

module spmc_top (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire spmc_pkg::spmc_event_type serialEvent,
  output spmc_pkg::spmc_mode_type    portMode,
  output logic                       rxEnable,
  output logic                       multiprocFilter,
  output logic                       txNinthBit,
  output logic                       rxNinthBit,
  output logic                       txDoneFlag,
  output logic                       rxDoneFlag
);
  import spmc_pkg::*;

  logic [7:0]  ctl_r;
  logic [7:0]  ctl_nxt;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  function automatic logic nineBitMode(input logic [1:0] m);
    nineBitMode = m[1];
  endfunction

  // bus decode
  wire       hitCtl   = (paddr == `SPMC_SERIAL_CONTROL_ADDR);
  wire       setupCyc = psel & ~penable;
  wire       accessWr = psel & penable & pready_r & pwrite & hitCtl;
  wire [31:0] rdValue = hitCtl ? {24'h000000, ctl_r} : 32'h00000000;

  // current mode and control bits
  wire [1:0] modeSel = {ctl_r[`SPMC_MODE_HI_BIT], ctl_r[`SPMC_MODE_LO_BIT]};
  wire       filt     = ctl_r[`SPMC_FILTER_BIT];
  wire       ren      = ctl_r[`SPMC_RX_ENABLE_BIT];
  wire       nineMode = nineBitMode(modeSel);
  wire       mode1    = (modeSel == 2'b01);

  // frames arrive only while reception is enabled
  wire rxFrame = serialEvent.rxEnd & ren;
  wire rxReject = filt & ~serialEvent.rxBit & (nineMode | mode1);
  wire rxAccept = rxFrame & ~rxReject;
  wire rxLoadBit = rxFrame & (nineMode | (mode1 & ~filt));

  wire [7:0] ctlWritten = accessWr ? pwdata[7:0] : ctl_r;

  // hardware set wins over a software clear in the same cycle
  always_comb begin
    ctl_nxt = ctlWritten;
    if (rxLoadBit) begin
      ctl_nxt[`SPMC_RX_NINTH_BIT] = serialEvent.rxBit;
    end
    if (serialEvent.txEnd) begin
      ctl_nxt[`SPMC_TX_DONE_BIT] = 1'b1;
    end
    if (rxAccept) begin
      ctl_nxt[`SPMC_RX_DONE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_r <= `SPMC_SERIAL_CONTROL_RST;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // zero-wait access phase; read data and error latched at setup
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setupCyc;
      pslverr_r <= setupCyc & ~hitCtl;
      if (setupCyc & ~pwrite) begin
        prdata_r <= rdValue;
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign portMode        = spmc_mode_type'(modeSel);
  assign multiprocFilter = filt;
  assign rxEnable        = ren;
  assign txNinthBit      = ctl_r[`SPMC_TX_NINTH_BIT];
  assign rxNinthBit      = ctl_r[`SPMC_RX_NINTH_BIT];
  assign txDoneFlag      = ctl_r[`SPMC_TX_DONE_BIT];
  assign rxDoneFlag      = ctl_r[`SPMC_RX_DONE_BIT];

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_ctlWrite;
    psel && !penable && pwrite && hitCtl
    ##1 psel && penable && pready;
  endsequence

  sequence s_rxFrame;
    serialEvent.rxEnd && rxEnable;
  endsequence

  property p_txDoneSet;
    serialEvent.txEnd |=> txDoneFlag [*1]
      ##1 (txDoneFlag || $past(accessWr));
  endproperty
  a_txDoneSet: assert property (p_txDoneSet)
    else $error("transmit-done flag not set or lost");

  property p_ninthCapture;
    s_rxFrame and nineBitMode(portMode)
      |=> rxNinthBit == $past(serialEvent.rxBit);
  endproperty
  a_ninthCapture: assert property (p_ninthCapture)
    else $error("ninth received bit not captured");

  property p_stopCapture;
    s_rxFrame and portMode == SPMC_UART8_VAR && !multiprocFilter
      |=> rxNinthBit == $past(serialEvent.rxBit) && rxDoneFlag;
  endproperty
  a_stopCapture: assert property (p_stopCapture)
    else $error("stop bit not stored in mode one");

  property p_shiftMode;
    s_rxFrame and portMode == SPMC_SHIFT_REG && !accessWr
      |=> rxDoneFlag && $stable(rxNinthBit);
  endproperty
  a_shiftMode: assert property (p_shiftMode)
    else $error("shift mode receive handling wrong");

  property p_modeDecode;
    s_ctlWrite |=> portMode == spmc_mode_type'($past(pwdata[7:6], 1));
  endproperty
  a_modeDecode: assert property (p_modeDecode)
    else $error("mode field not taken from write");

  property p_filterReject;
    s_rxFrame and nineBitMode(portMode) && multiprocFilter
      && !serialEvent.rxBit && !rxDoneFlag && !accessWr
      |=> !rxDoneFlag;
  endproperty
  a_filterReject: assert property (p_filterReject)
    else $error("data frame raised receive-done under filter");

  // control byte as the pins show it
  wire [7:0] ctlPins = {portMode, multiprocFilter, rxEnable, txNinthBit,
                        rxNinthBit, txDoneFlag, rxDoneFlag};

  sequence s_setup;
    psel && !penable;
  endsequence

  // bus answers in the cycle right after setup
  property p_readyAfterSetup;
    s_setup |=> pready;
  endproperty
  a_readyAfterSetup: assert property (p_readyAfterSetup)
    else $error("ready missing in the access cycle");

  property p_readyPulse;
    pready |=> !pready;
  endproperty
  a_readyPulse: assert property (p_readyPulse)
    else $error("ready held beyond one cycle");

  // unknown addresses answer with an error
  property p_missError;
    s_setup ##0 !hitCtl |=> pready && pslverr;
  endproperty
  a_missError: assert property (p_missError)
    else $error("no error for an unmapped address");

  property p_hitNoError;
    s_setup ##0 hitCtl |=> pready && !pslverr;
  endproperty
  a_hitNoError: assert property (p_hitNoError)
    else $error("error raised for the control register");

  // read data is the control byte as it stood at setup
  property p_readData;
    s_setup ##0 !pwrite ##0 hitCtl
      |=> prdata == {24'h000000, $past(ctlPins)};
  endproperty
  a_readData: assert property (p_readData)
    else $error("read data differs from the control byte");

  // software-owned bits move only under a write
  property p_ctlHeld;
    !accessWr |=> $stable(portMode) && $stable(multiprocFilter)
      && $stable(rxEnable) && $stable(txNinthBit);
  endproperty
  a_ctlHeld: assert property (p_ctlHeld)
    else $error("control bits changed without a write");

  // done flags stay set until software clears them
  property p_txDoneHold;
    txDoneFlag && !accessWr |=> txDoneFlag;
  endproperty
  a_txDoneHold: assert property (p_txDoneHold)
    else $error("transmit-done flag dropped without a write");

  property p_rxDoneHold;
    rxDoneFlag && !accessWr |=> rxDoneFlag;
  endproperty
  a_rxDoneHold: assert property (p_rxDoneHold)
    else $error("receive-done flag dropped without a write");

  // a disabled receiver ignores frame ends
  property p_rxRefused;
    serialEvent.rxEnd && !rxEnable && !accessWr
      |=> $stable(rxDoneFlag) && $stable(rxNinthBit);
  endproperty
  a_rxRefused: assert property (p_rxRefused)
    else $error("frame taken while reception disabled");

endmodule

// ---- verilog/spmc_defs.svh ----
// constants of the serial port mode and status control block
// assumes an APB slave with 32-bit data and a 12-bit byte address
//
// Contract
// - set transmit-done flag at end of frame
// - modes 2 and 3 capture ninth bit
// - mode 1, filter clear: store stop bit
// - mode bits 00 select shift register mode
// - decode 01, 10, 11 as modes 1-3
`ifndef SPMC_DEFS_SVH
`define SPMC_DEFS_SVH

`define SPMC_SERIAL_CONTROL_ADDR 12'h098
`define SPMC_SERIAL_CONTROL_RST  8'h00

`define SPMC_MODE_HI_BIT   7
`define SPMC_MODE_LO_BIT   6
`define SPMC_FILTER_BIT    5
`define SPMC_RX_ENABLE_BIT 4
`define SPMC_TX_NINTH_BIT  3
`define SPMC_RX_NINTH_BIT  2
`define SPMC_TX_DONE_BIT   1
`define SPMC_RX_DONE_BIT   0

// mode 2 runs at this fraction of the oscillator input
`define SPMC_MODE2_OSC_DIV 8'h40

`endif

// ---- verilog/spmc_pkg.sv ----
// types of the serial port mode and status control block
// assumes the shift datapath reports frame ends on the same clock
package spmc_pkg;

  typedef enum logic [1:0] {
    SPMC_SHIFT_REG   = 2'b00,
    SPMC_UART8_VAR   = 2'b01,
    SPMC_UART9_FIXED = 2'b10,
    SPMC_UART9_VAR   = 2'b11
  } spmc_mode_type;

  // frame-end reports from the shift datapath, one-cycle pulses
  typedef struct packed {
    logic txEnd;
    logic rxEnd;
    logic rxBit;
  } spmc_event_type;

endpackage

// ---- test/spmc_peer.sv ----
// serial peer model: frame-end reports toward the control block
// assumes the bench calls pulse right after a rising clock edge
`timescale 1ns/1ps
module spmc_peer (
  input  wire logic                clk,
  output spmc_pkg::spmc_event_type serialEvent
);
  import spmc_pkg::*;
  initial serialEvent = '0;
  // one-cycle report, then rxBit flips so no stale level lingers
  task pulse(input logic t, input logic r, input logic b);
    serialEvent <= '{t, r, b};
    @(posedge clk);
    serialEvent <= '{1'b0, 1'b0, ~b};
  endtask
endmodule

// ---- test/test_spmc_top.sv ----
// self-checking bench: control register over APB, frame-end events
// assumes one 10 MHz clock and the peer model on the event port
`timescale 1ns/1ps
`include "spmc_defs.svh"
module test_spmc_top;
  import spmc_pkg::*;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdData;
  logic pready, pslverr, rdErr;
  spmc_event_type serialEvent;
  spmc_mode_type portMode;
  logic rxEnable, multiprocFilter, txNinthBit, rxNinthBit;
  logic txDoneFlag, rxDoneFlag;
  wire [31:0] pinWord = {24'h0, portMode, multiprocFilter, rxEnable,
    txNinthBit, rxNinthBit, txDoneFlag, rxDoneFlag};
  int n_errors = 0, checks = 0;
  spmc_peer u_spmc_peer (.clk(clk), .serialEvent(serialEvent));
  spmc_top u_spmc_top (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serialEvent(serialEvent), .portMode(portMode), .rxEnable(rxEnable),
    .multiprocFilter(multiprocFilter), .txNinthBit(txNinthBit),
    .rxNinthBit(rxNinthBit), .txDoneFlag(txDoneFlag),
    .rxDoneFlag(rxDoneFlag));
  initial forever #50 clk = ~clk;
  task final_report;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    i = 0;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rdData = prdata;
    rdErr = pslverr;
    if (pready !== 1'b1) begin
      n_errors++;
      final_report;
    end
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  // write, fire an event, read back the whole control byte
  task rx_case(input logic [7:0] w, input logic t, input logic r,
               input logic b, output logic [31:0] q);
    apb(1, `SPMC_SERIAL_CONTROL_ADDR, w);
    u_spmc_peer.pulse(t, r, b);
    apb(0, `SPMC_SERIAL_CONTROL_ADDR, 8'h00);
    q = rdData;
  endtask
  task s_modes;
    for (int m = 0; m < 4; m++) begin
      apb(1, `SPMC_SERIAL_CONTROL_ADDR, 8'(m << 6));
      chk({30'h0, portMode}, 32'(m));
    end
  endtask
  task s_events;
    logic [31:0] q;
    rx_case(8'h40, 1, 0, 0, q); chk(q, 32'h42);
    chk({31'h0, txDoneFlag}, 32'h1);
    rx_case(8'hF0, 0, 1, 0, q); chk(q, 32'hF0);
    rx_case(8'hF0, 0, 1, 1, q); chk(q, 32'hF5);
    rx_case(8'hB0, 0, 1, 1, q); chk(q, 32'hB5);
    rx_case(8'h50, 0, 1, 1, q); chk(q, 32'h55);
    rx_case(8'h54, 0, 1, 0, q); chk(q, 32'h51);
    rx_case(8'h10, 0, 1, 1, q); chk(q, 32'h11);
  endtask
  // set wins over a clearing write; pins mirror the control byte
  task s_pins;
    logic [31:0] q;
    apb(1, `SPMC_SERIAL_CONTROL_ADDR, 8'hD0);
    fork
      apb(1, `SPMC_SERIAL_CONTROL_ADDR, 8'hD8);
      begin
        @(posedge clk);
        u_spmc_peer.pulse(1, 1, 1);
      end
    join
    apb(0, `SPMC_SERIAL_CONTROL_ADDR, 8'h00);
    chk(rdData, 32'hDF);
    chk(pinWord, 32'hDF);
    rx_case(8'h80, 0, 1, 1, q); chk(q, 32'h80);
    chk(pinWord, 32'h80);
    rx_case(8'h2A, 0, 0, 0, q); chk(q, 32'h2A);
    chk(pinWord, 32'h2A);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    s_modes;
    s_events;
    s_pins;
    apb(0, 12'h09C, 8'h00);
    chk({31'h0, rdErr}, 32'h1);
    final_report;
  end
endmodule
